// [hw/rla_pkg.sv]
package rla_pkg;
  localparam int NUM_LANES = 20;
  localparam int IDX_W     = 5;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int MMCNT_W   = 16;

  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SYNCED = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_LOCK   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_MMCNT  = 8'h10;

  localparam int CTRL_MM_EN_BIT = 0;
  localparam logic CTRL_MM_EN_RESET = 1'b1;

  localparam int ST_ALIGNED_BIT     = 0;
  localparam int ST_LINK_GOOD_BIT   = 1;
  localparam int ST_DESKEW_LOST_BIT = 2;
  localparam int ST_FAR_FAULT_BIT   = 3;
  localparam int ST_LOCAL_FAULT_BIT = 4;
  localparam int ST_ALL_SEEN_BIT    = 5;
endpackage

// [hw/rla_status.sv]
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// - all_lanes_deskewed is 1 while every lane is aligned and deskewed, else 0.
// - After the first enabled clock past reset, all_lanes_deskewed at 0 means a local fault is reported.
// - all_lanes_deskewed mirrors management bit 3.50.12.
// - pcs_link_good is high only while aligned and not in high error rate state.
// - lane_block_lock gives one level bit per lane for block lock.
// - deskew_lost rises on an alignment error or loss of achieved alignment.
// - marker_mismatch_pulse flags an unexpected lane marker across the lanes.
// - Mismatch only after markers seen on all lanes, then a wrong marker.
// - Mismatch is reported at the first metaframe boundary after the wrong marker arrives.
// - No mismatch while markers have never been received correctly.
// - Mismatch is a one-cycle pulse; back-to-back pulses are allowed.
// - far_end_fault is 1 while a remote fault is detected, else 0.
// - Twenty 5-bit lane_source_index levels, one per lane, name its physical lane.
// - Malformed marker words go to marker_word_bad, not the mismatch pulse.
// - A lane_word_synced bit sets only after word sync and a received marker.
// - local_fault is high when internal or received local fault is present.
// - marker_word_bad pulses one cycle per malformed marker on that lane.
module rla_status #(
  parameter int LANES = rla_pkg::NUM_LANES
) (
  input  wire logic                            clk,                    // Receive clock
  input  wire logic                            rst_n,                  // Async reset, active low
  input  wire logic                            clk_en,                 // Freezes all state when low
  input  wire logic [LANES-1:0]                lane_block_lock_in,     // Per-lane block lock from lock FSMs
  input  wire logic [LANES-1:0]                lane_word_sync_in,      // Per-lane word boundary sync
  input  wire logic [LANES-1:0]                lane_marker_seen,       // Well-formed marker received
  input  wire logic [LANES-1:0]                lane_marker_ok,         // Marker matched expected lane
  input  wire logic [LANES-1:0]                lane_marker_malformed,  // Badly formed marker word
  input  wire logic [rla_pkg::IDX_W-1:0]       phys_lane_in [LANES],   // Physical lane per PCS lane
  input  wire logic                            deskew_done_in,         // Aligner reports deskew done
  input  wire logic                            deskew_error_in,        // Aligner error strobe
  input  wire logic                            metaframe_tick,         // One cycle per metaframe
  input  wire logic                            high_error_rate_state,  // High error rate state
  input  wire logic                            remote_fault_in,        // Remote fault detected
  input  wire logic                            received_local_fault,   // Local fault from partner
  input  wire logic [rla_pkg::ADDR_W-1:0]      avs_address,            // Byte address
  input  wire logic                            avs_read,               // Read request
  input  wire logic                            avs_write,              // Write request
  input  wire logic [rla_pkg::DATA_W-1:0]      avs_writedata,          // Write data
  input  wire logic [3:0]                      avs_byteenable,         // Byte enables
  output var  logic [rla_pkg::DATA_W-1:0]      avs_readdata,           // Read data
  output logic                                 avs_waitrequest,        // Stall
  output var  logic                            all_lanes_deskewed,     // All lanes aligned
  output var  logic                            pcs_link_good,          // Aligned and error rate fine
  output var  logic [LANES-1:0]                lane_block_lock,        // Per-lane block lock
  output var  logic                            deskew_lost,            // Alignment error or loss
  output var  logic                            marker_mismatch_pulse,  // Marker mismatch event
  output var  logic                            far_end_fault,          // Remote fault level
  output var  logic                            local_fault,            // Local fault level
  output var  logic [LANES-1:0]                lane_word_synced,       // Word sync plus marker
  output var  logic [LANES-1:0]                marker_word_bad,        // Malformed marker pulse
  output var  logic [rla_pkg::IDX_W-1:0]       lane_source_index [LANES] // Physical lane per lane
);
  import rla_pkg::*;

  generate
    if (LANES < 1 || LANES > DATA_W || LANES > (1 << IDX_W)) begin : g_bad_lanes
      $error("rla_status: LANES out of supported range");
    end
  endgenerate

  function automatic logic [DATA_W-1:0] pad_word(input logic [LANES-1:0] v);
    logic [DATA_W-1:0] w;
    w = '0;
    w[LANES-1:0] = v;
    return w;
  endfunction

  function automatic logic idx_legal(input logic [IDX_W-1:0] idx);
    return int'(idx) < LANES;
  endfunction

  logic [LANES-1:0]   synced_reg, synced_next;
  logic [LANES-1:0]   seen_ok_reg, seen_ok_next;
  logic               aligned_reg, aligned_next;
  logic               link_good_reg;
  logic               deskew_lost_reg, deskew_lost_next;
  logic               pend_reg, pend_next;
  logic               mm_pulse_reg;
  logic               far_fault_reg;
  logic               local_fault_reg;
  logic [LANES-1:0]   lock_reg;
  logic [LANES-1:0]   mf_bad_reg;
  logic [IDX_W-1:0]   idx_reg [LANES];
  logic               all_seen;
  logic               mm_err;
  logic               mm_en_reg;
  logic [MMCNT_W-1:0] mmcnt_reg;
  logic               ack_reg;
  logic [DATA_W-1:0]  rdata_reg, rdata_next;
  logic               req;
  logic               wr_take;

  // Lane tracking
  always_comb begin
    synced_next  = lane_word_sync_in & (synced_reg | lane_marker_seen);
    seen_ok_next = lane_word_sync_in & (seen_ok_reg | (lane_marker_seen & lane_marker_ok));
    aligned_next = (&synced_reg) & deskew_done_in;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      synced_reg  <= '0;
      seen_ok_reg <= '0;
      lock_reg    <= '0;
      mf_bad_reg  <= '0;
    end else if (clk_en) begin
      synced_reg  <= synced_next;
      seen_ok_reg <= seen_ok_next;
      lock_reg    <= lane_block_lock_in;
      mf_bad_reg  <= lane_marker_malformed;
    end
  end

  // Out-of-range sources keep the last legal index rather than leak a bogus lane
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LANES; i++) idx_reg[i] <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < LANES; i++) begin
        if (idx_legal(phys_lane_in[i])) idx_reg[i] <= phys_lane_in[i];
      end
    end
  end

  // Alignment and health levels
  always_comb begin
    deskew_lost_next = deskew_lost_reg;
    if (deskew_error_in || (aligned_reg && !aligned_next)) begin
      deskew_lost_next = 1'b1;
    end else if (aligned_next) begin
      deskew_lost_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aligned_reg     <= 1'b0;
      link_good_reg   <= 1'b0;
      deskew_lost_reg <= 1'b0;
      far_fault_reg   <= 1'b0;
      local_fault_reg <= 1'b0;
    end else if (clk_en) begin
      aligned_reg     <= aligned_next;
      link_good_reg   <= aligned_next && !high_error_rate_state;
      deskew_lost_reg <= deskew_lost_next;
      far_fault_reg   <= remote_fault_in;
      // Missing alignment counts as internal local fault
      local_fault_reg <= !aligned_next || high_error_rate_state || received_local_fault;
    end
  end

  // Marker mismatch: an error is parked until the next metaframe boundary
  assign all_seen = &seen_ok_reg;
  assign mm_err   = all_seen && |(lane_marker_seen & ~lane_marker_ok);

  always_comb begin
    pend_next = (pend_reg && !metaframe_tick) || mm_err;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg     <= 1'b0;
      mm_pulse_reg <= 1'b0;
    end else if (clk_en) begin
      pend_reg     <= pend_next;
      mm_pulse_reg <= metaframe_tick && pend_reg && mm_en_reg;
    end
  end

  // Register bus: one wait state, read data loaded on the stalled edge
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_reg;
  assign wr_take         = avs_write && ack_reg;

  always_comb begin
    rdata_next = '0;
    case (avs_address)
      OFF_CTRL:   rdata_next[CTRL_MM_EN_BIT] = mm_en_reg;
      OFF_STATUS: begin
        rdata_next[ST_ALIGNED_BIT]     = aligned_reg;
        rdata_next[ST_LINK_GOOD_BIT]   = link_good_reg;
        rdata_next[ST_DESKEW_LOST_BIT] = deskew_lost_reg;
        rdata_next[ST_FAR_FAULT_BIT]   = far_fault_reg;
        rdata_next[ST_LOCAL_FAULT_BIT] = local_fault_reg;
        rdata_next[ST_ALL_SEEN_BIT]    = all_seen;
      end
      OFF_SYNCED: rdata_next = pad_word(synced_reg);
      OFF_LOCK:   rdata_next = pad_word(lock_reg);
      OFF_MMCNT:  rdata_next[MMCNT_W-1:0] = mmcnt_reg;
      default:    rdata_next = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else if (clk_en) begin
      ack_reg <= req && !ack_reg;
      if (avs_read && !ack_reg) rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mm_en_reg <= CTRL_MM_EN_RESET;
    end else if (clk_en && wr_take && avs_address == OFF_CTRL && avs_byteenable[0]) begin
      mm_en_reg <= avs_writedata[CTRL_MM_EN_BIT];
    end
  end

  // Saturating event count; an event in the cycle of a clearing write restarts it at 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mmcnt_reg <= '0;
    end else if (clk_en) begin
      if (mm_pulse_reg) begin
        if (wr_take && avs_address == OFF_MMCNT) mmcnt_reg <= MMCNT_W'(1);
        else if (mmcnt_reg != '1) mmcnt_reg <= mmcnt_reg + MMCNT_W'(1);
      end else if (wr_take && avs_address == OFF_MMCNT) begin
        mmcnt_reg <= '0;
      end
    end
  end

  assign avs_readdata          = rdata_reg;
  assign all_lanes_deskewed    = aligned_reg;
  assign pcs_link_good         = link_good_reg;
  assign lane_block_lock       = lock_reg;
  assign deskew_lost           = deskew_lost_reg;
  assign marker_mismatch_pulse = mm_pulse_reg;
  assign far_end_fault         = far_fault_reg;
  assign local_fault           = local_fault_reg;
  assign lane_word_synced      = synced_reg;
  assign marker_word_bad       = mf_bad_reg;
  assign lane_source_index     = idx_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic idx_any_bad;
  always_comb begin
    idx_any_bad = 1'b0;
    for (int i = 0; i < LANES; i++) idx_any_bad = idx_any_bad | !idx_legal(idx_reg[i]);
  end

  a_aligned_all_synced: assert property (clk_en |=> all_lanes_deskewed == ($past(&synced_reg) && $past(deskew_done_in)))
    else $error("aligned level does not follow lane sync and deskew");
  a_link_good_hber: assert property (clk_en |=> pcs_link_good == (all_lanes_deskewed && !$past(high_error_rate_state)))
    else $error("link good wrong for alignment or error rate");
  a_local_fault_or: assert property (rst_n && clk_en |=> local_fault == (!all_lanes_deskewed
    || $past(high_error_rate_state) || $past(received_local_fault)))
    else $error("local fault not the OR of its causes");
  a_deskew_lost_set: assert property (clk_en && deskew_error_in |=> deskew_lost)
    else $error("deskew lost not raised after aligner error");
  a_mismatch_on_tick: assert property (marker_mismatch_pulse && $past(clk_en)
    |-> $past(metaframe_tick) && $past(pend_reg))
    else $error("mismatch pulse outside a metaframe boundary");
  a_mismatch_needs_seen: assert property (clk_en && !all_seen && !pend_reg |=> !pend_reg)
    else $error("mismatch pending before all markers seen");
  a_far_end_level: assert property (clk_en |=> far_end_fault == $past(remote_fault_in))
    else $error("far end fault does not track remote fault");
  a_synced_needs_sync: assert property (clk_en |=> (lane_word_synced & ~$past(lane_word_sync_in)) == '0)
    else $error("lane synced without word sync");
  a_word_bad_pulse: assert property (clk_en |=> marker_word_bad == $past(lane_marker_malformed))
    else $error("marker word error not a one-cycle copy");
  a_index_in_range: assert property (!idx_any_bad)
    else $error("lane source index out of range");
  a_block_lock_copy: assert property (rst_n && clk_en |=> lane_block_lock == $past(lane_block_lock_in))
    else $error("block lock level does not follow its input");
  a_link_hber_off: assert property (rst_n && clk_en && high_error_rate_state |=> !pcs_link_good)
    else $error("link good high in high error rate state");
  a_link_needs_aligned: assert property (pcs_link_good |-> all_lanes_deskewed)
    else $error("link good without alignment");
  a_unaligned_fault: assert property ($past(rst_n) && $past(clk_en) && !all_lanes_deskewed |-> local_fault)
    else $error("no local fault while alignment is absent");
  a_deskew_lost_drop: assert property ($fell(all_lanes_deskewed) |-> deskew_lost)
    else $error("deskew lost not raised when alignment dropped");
  a_mismatch_after_seen: assert property ($rose(pend_reg) |-> $past(all_seen))
    else $error("mismatch parked before all markers seen");
  a_mismatch_gated: assert property (marker_mismatch_pulse |-> $past(mm_en_reg))
    else $error("mismatch pulse while disabled");
  a_synced_sets: assert property (rst_n && clk_en && lane_word_sync_in[0]
    && lane_marker_seen[0] |=> lane_word_synced[0])
    else $error("lane synced not set after marker");
  a_index_follows: assert property (rst_n && clk_en && idx_legal(phys_lane_in[0])
    |=> lane_source_index[0] == $past(phys_lane_in[0]))
    else $error("lane source index does not follow a legal input");

  // A frozen clock enable must hold the fault outputs far_end_fault and local_fault
  a_freeze_hold: assert property (rst_n && !clk_en |=> $stable(far_end_fault) && $stable(local_fault))
    else $error("state moved while clock enable low");
  a_wait_one_cycle: assert property (rst_n && clk_en && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one wait state");

  c_mismatch_seen: cover property (marker_mismatch_pulse);
  c_mismatch_b2b: cover property (marker_mismatch_pulse ##1 marker_mismatch_pulse);
  c_link_good: cover property (pcs_link_good);
  c_deskew_lost: cover property (all_lanes_deskewed ##1 deskew_lost);
  c_frozen: cover property (!clk_en ##1 !clk_en);
endmodule
`default_nettype wire

// [verif/rla_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module rla_monitor (
  input  wire logic                        clk,                                         // Receive clock
  input  wire logic                        rst_n,                                       // Async reset, active low
  input  wire logic [rla_pkg::NUM_LANES-1:0] lane_word_synced,                          // Per-lane sync
  input  wire logic [rla_pkg::IDX_W-1:0]   lane_source_index [rla_pkg::NUM_LANES],      // Reported source
  output var  logic [rla_pkg::IDX_W-1:0]   trusted_index [rla_pkg::NUM_LANES]           // Last index taken
);
  import rla_pkg::*;
  // A stale index from an unsynced lane would misroute lane data, so it is never taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trusted_index <= '{default: '0};
    end else begin
      for (int i = 0; i < NUM_LANES; i++) begin
        if (lane_word_synced[i]) trusted_index[i] <= lane_source_index[i];
      end
    end
  end
endmodule
`default_nettype wire

// [verif/rla_status_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module rla_status_tb_top;
  import rla_pkg::*;
  logic        clk, rst_n, clk_en, done_in, err_in, tick, err_rate, rem_in, rlf_in, rd, wr;
  logic [19:0] lock_in, sync_in, seen, ok, malf, blk, synced, mwb;
  logic [4:0]  phys [20];
  logic [4:0]  idx [20];
  logic [4:0]  trust [20];
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic        waitreq, aligned, link_good, dlost, mm, fef, lf;
  int          fail_count, comparisons;

  rla_status dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .lane_block_lock_in(lock_in),
    .lane_word_sync_in(sync_in), .lane_marker_seen(seen), .lane_marker_ok(ok), .lane_marker_malformed(malf),
    .phys_lane_in(phys), .deskew_done_in(done_in), .deskew_error_in(err_in), .metaframe_tick(tick),
    .high_error_rate_state(err_rate), .remote_fault_in(rem_in), .received_local_fault(rlf_in),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf),
    .avs_readdata(rdata), .avs_waitrequest(waitreq), .all_lanes_deskewed(aligned), .pcs_link_good(link_good),
    .lane_block_lock(blk), .deskew_lost(dlost), .marker_mismatch_pulse(mm), .far_end_fault(fef),
    .local_fault(lf), .lane_word_synced(synced), .marker_word_bad(mwb), .lane_source_index(idx));
  rla_monitor mon (.clk(clk), .rst_n(rst_n), .lane_word_synced(synced), .lane_source_index(idx),
    .trusted_index(trust));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task cmp(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task final_report;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task w(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task bus(logic wn, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= wn;
    rd <= !wn;
    do @(posedge clk); while (waitreq !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task t_never_ok;
    @(posedge clk) sync_in <= 20'hfffff;
    w(2);
    cmp("synced no marker", 20'h0, synced);
    @(posedge clk) seen <= 20'hfffff;
    @(posedge clk) seen <= 20'h0;
    tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
    @(negedge clk) cmp("mm never ok", 0, mm);
  endtask

  task t_align;
    @(posedge clk) seen <= 20'hfffff;
    ok <= 20'hfffff;
    done_in <= 1'b1;
    @(posedge clk) seen <= 20'h0;
    w(1);
    cmp("aligned", 1, aligned);
    cmp("link good", 1, link_good);
    cmp("local fault", 0, lf);
    cmp("block lock", 20'hfffff, blk);
    cmp("synced", 20'hfffff, synced);
  endtask

  task t_faults;
    @(posedge clk) err_rate <= 1'b1;
    rem_in <= 1'b1;
    w(1);
    cmp("link err rate", 0, link_good);
    cmp("lf err rate", 1, lf);
    cmp("far fault", 1, fef);
    @(posedge clk) {err_rate, rem_in, rlf_in} <= 3'h1;
    w(1);
    cmp("lf received", 1, lf);
    cmp("far fault off", 0, fef);
    @(posedge clk) rlf_in <= 1'b0;
    w(1);
    cmp("lf clear", 0, lf);
  endtask

  task t_index;
    for (int i = 0; i < 20; i++) cmp("source index", 32'(19 - i), 32'(idx[i]));
    @(posedge clk) phys[2] <= 5'h14;
    lock_in <= 20'h5a5a5;
    w(2);
    cmp("index refused", 5'h11, idx[2]);
    cmp("block lock change", 20'h5a5a5, blk);
  endtask

  task t_mismatch;
    @(posedge clk) seen <= 20'h8;
    ok <= 20'h0;
    @(posedge clk) tick <= 1'b1;
    @(negedge clk) cmp("mm before tick", 0, mm);
    @(posedge clk) seen <= 20'h0;
    ok <= 20'hfffff;
    @(negedge clk) cmp("mm first", 1, mm);
    @(posedge clk) tick <= 1'b0;
    @(negedge clk) cmp("mm adjacent", 1, mm);
    w(1);
    cmp("mm ends", 0, mm);
    @(posedge clk) malf <= 20'h20;
    @(posedge clk) malf <= 20'h0;
    tick <= 1'b1;
    @(negedge clk) cmp("word bad", 20'h20, mwb);
    @(posedge clk) tick <= 1'b0;
    @(negedge clk) cmp("word bad once", 20'h0, mwb);
    cmp("mm malformed", 0, mm);
  endtask

  task t_regs;
    bus(1'b0, OFF_STATUS, 32'h0, q);
    cmp("status reg", (32'h1 << ST_ALIGNED_BIT) | (32'h1 << ST_LINK_GOOD_BIT) | (32'h1 << ST_ALL_SEEN_BIT), q);
    bus(1'b0, OFF_SYNCED, 32'h0, q);
    cmp("synced reg", 32'hfffff, q);
    bus(1'b0, OFF_MMCNT, 32'h0, q);
    cmp("mm count", 32'h2, q);
    bus(1'b1, OFF_MMCNT, 32'h0, q);
    bus(1'b0, OFF_MMCNT, 32'h0, q);
    cmp("mm count clr", 32'h0, q);
    bus(1'b0, OFF_CTRL, 32'h0, q);
    cmp("ctrl reset", 32'h1, q);
    bus(1'b1, OFF_CTRL, 32'h0, q);
    bus(1'b0, OFF_CTRL, 32'h0, q);
    cmp("ctrl off", 32'h0, q);
    @(posedge clk) seen <= 20'h8;
    ok <= 20'h0;
    @(posedge clk) seen <= 20'h0;
    ok <= 20'hfffff;
    tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
    @(negedge clk) cmp("mm gated", 0, mm);
    bus(1'b1, OFF_CTRL, 32'h1, q);
    bus(1'b0, 8'h40, 32'h0, q);
    cmp("unmapped", 32'h0, q);
  endtask

  task t_loss;
    @(posedge clk) sync_in <= 20'hfff7f;
    phys[7] <= 5'h3;
    w(1);
    cmp("synced drop", 20'hfff7f, synced);
    w(2);
    cmp("aligned lost", 0, aligned);
    cmp("deskew lost", 1, dlost);
    cmp("lf unaligned", 1, lf);
    cmp("trusted held", 5'hc, trust[7]);
    @(posedge clk) sync_in <= 20'hfffff;
    seen <= 20'h80;
    @(posedge clk) seen <= 20'h0;
    w(2);
    cmp("realigned", 1, aligned);
    cmp("deskew ok", 0, dlost);
    @(posedge clk) err_in <= 1'b1;
    @(posedge clk) err_in <= 1'b0;
    @(negedge clk) cmp("deskew err", 1, dlost);
    @(posedge clk) clk_en <= 1'b0;
    rem_in <= 1'b1;
    w(2);
    cmp("frozen far fault", 0, fef);
    @(posedge clk) clk_en <= 1'b1;
    w(1);
    cmp("far fault after freeze", 1, fef);
  endtask

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    {done_in, err_in, tick, err_rate, rem_in, rlf_in, rd, wr} = '0;
    {sync_in, seen, ok, malf} = '0;
    lock_in = 20'hfffff;
    {addr, wdata} = '0;
    for (int i = 0; i < 20; i++) phys[i] = 5'(19 - i);
    @(posedge clk);
    @(negedge clk) cmp("lock in reset", 20'h0, blk);
    cmp("idx in reset", 5'h0, idx[0]);
    @(posedge clk) rst_n <= 1'b1;
    t_never_ok();
    t_align();
    t_faults();
    t_index();
    t_mismatch();
    t_regs();
    t_loss();
    final_report();
  end

  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
